// *** src/sadc_pkg.sv ***
// Constants, types and helpers for the serial converter control block.
// Assumes one system clock at CLK_HZ and a host-driven serial clock.

package sadc_pkg;

   // ****************************************
   // Conversion frame
   // ****************************************
   localparam int ADC_BITS = 12;
   localparam int LEAD_ZEROS = 3;
   localparam int MSB_EDGE = LEAD_ZEROS + 1;
   localparam int CONV_EDGES = 16;
   localparam int TRACK_EDGE = 14;
   localparam int PD_FIRST_EDGE = 4;
   localparam int PD_LAST_EDGE = 14;
   localparam int EXIT_LOW_EDGES = 14;
   localparam int PARTIAL_WAKE_LATENCY = 16;
   localparam int CNT_W = 5;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 25000000;
   localparam int PWRUP_TIME_MS = 2;
   localparam int PWRUP_CYC = (PWRUP_TIME_MS * CLK_HZ + 999) / 1000;

   // ****************************************
   // Power mode codes, one bit changes per step
   // ****************************************
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_PART = 2'h1;
   localparam logic [1:0] MODE_FULL = 2'h3;
   localparam logic [1:0] MODE_WAKE = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE, ST_CONV, ST_TAIL, ST_PDP, ST_PDF, ST_RECOVER, ST_WAKE
   } sadc_state_t;

   function automatic logic sadc_in_range(input logic [CNT_W-1:0] c,
                                          input int lo, input int hi);
      return (int'(c) >= lo) && (int'(c) <= hi);
   endfunction

endpackage

// *** src/sadc_sync.sv ***
// Two-stage synchroniser for levels and toggles.
// Assumes each bit changes alone or is gray-coded with its neighbours.
`timescale 1ns/1ns

module sadc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk,
   input wire logic [WIDTH-1:0] i_d,
   output logic [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] q_d;

   // No reset: the reset itself passes through here
   always_comb begin
      meta_d = i_d;
      q_d = meta_q;
   end

   always_ff @(posedge i_clk) begin
      meta_q <= meta_d;
      o_q <= q_d;
   end
endmodule

// *** src/sadc_top.sv ***
// Conversion sequencer and serial readout of a 12-bit SAR converter.
// Assumes the host drives the trigger in step with its serial clock,
// and the comparator settles within one serial clock period.
`timescale 1ns/1ns

module sadc_top
   import sadc_pkg::*;
#(
   parameter bit BIPOLAR = 1'b0,
   parameter int PWRUP_CYCLES = sadc_pkg::PWRUP_CYC
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_sclk,
   input wire logic i_conversion_trigger,
   input wire logic i_cmp_above,
   output logic o_dout,
   output logic o_dout_oe,
   output logic o_track,
   output logic [sadc_pkg::ADC_BITS-1:0] o_dac_code,
   output logic [1:0] o_pwr_mode,
   output logic o_calibrated,
   output logic o_power_ready
);
   import sadc_pkg::*;

   localparam int PW = $clog2(PWRUP_CYCLES + 1);

   // ****************************************
   // Serial clock domain
   // ****************************************
   sadc_state_t st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d, k;
   logic [ADC_BITS-1:0] trial_q, trial_d;
   logic trig_q, oe_q, oe_d, dout_q, dout_d, hold_q, hold_d;
   logic cal_q, cal_d, wtgl_q, wtgl_d, dseen_q;
   logic [1:0] mode_q, mode_d;
   logic [1:0] s_sync;
   logic srst_n, done_s, fall, start;
   logic done_tgl_q;
   int idx;

   // Reset and wake-done toggle arrive from the system clock side
   sadc_sync #(.WIDTH(2)) u_sync_s (
      .i_clk(i_sclk),
      .i_d({done_tgl_q, i_nrst}),
      .o_q(s_sync)
   );
   assign srst_n = s_sync[0];
   assign done_s = s_sync[1];

   assign fall = trig_q && !i_conversion_trigger;
   assign start = (st_q == ST_IDLE) && fall;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      oe_d = oe_q;
      dout_d = dout_q;
      hold_d = hold_q;
      trial_d = trial_q;
      cal_d = cal_q;
      wtgl_d = wtgl_q;
      k = cnt_q + 5'h01;
      idx = ADC_BITS - 1 - (int'(k) - MSB_EDGE);
      unique case (st_q)
         ST_IDLE: begin
            if (fall) begin
               st_d = ST_CONV;
               cnt_d = 5'h01;
               oe_d = 1'b1;
               dout_d = 1'b0;
               hold_d = 1'b1;
               trial_d = '0;
            end
         end
         ST_CONV: begin
            cnt_d = k;
            dout_d = 1'b0;
            if (int'(k) == LEAD_ZEROS) begin
               trial_d = '0;
               trial_d[ADC_BITS-1] = 1'b1;
            end
            if (sadc_in_range(k, MSB_EDGE, MSB_EDGE + ADC_BITS - 1)) begin
               // One approximation step per rising edge
               trial_d[idx] = i_cmp_above;
               if (idx > 0) begin
                  trial_d[idx-1] = 1'b1;
               end
               // Offset binary to two's complement by MSB flip
               dout_d = (idx == ADC_BITS - 1 && BIPOLAR) ? !i_cmp_above
                                                         : i_cmp_above;
            end
            if (int'(k) == TRACK_EDGE) begin
               hold_d = 1'b0;
            end
            if (i_conversion_trigger &&
                sadc_in_range(k, PD_FIRST_EDGE, PD_LAST_EDGE)) begin
               st_d = ST_PDP;
               cnt_d = '0;
               oe_d = 1'b0;
               dout_d = 1'b0;
               hold_d = 1'b0;
            end else if (int'(k) == CONV_EDGES) begin
               cal_d = 1'b1;
               cnt_d = '0;
               // Early rise keeps the line for back-to-back frames
               st_d = i_conversion_trigger ? ST_IDLE : ST_TAIL;
            end
         end
         ST_TAIL: begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
            dout_d = 1'b0;
         end
         ST_PDP, ST_PDF: begin
            if (fall) begin
               cnt_d = 5'h01;
            end else if (cnt_q != '0) begin
               if (!i_conversion_trigger) begin
                  // Saturate one count past the exit length
                  cnt_d = (int'(cnt_q) > EXIT_LOW_EDGES) ? cnt_q : k;
               end else begin
                  cnt_d = '0;
                  if (int'(k) > EXIT_LOW_EDGES) begin
                     if (st_q == ST_PDP) begin
                        st_d = ST_RECOVER;
                     end else begin
                        st_d = ST_WAKE;
                        wtgl_d = !wtgl_q;
                     end
                  end else if (st_q == ST_PDP &&
                               int'(k) >= PD_FIRST_EDGE) begin
                     st_d = ST_PDF;
                  end
               end
            end
         end
         ST_RECOVER: begin
            cnt_d = k;
            if (int'(k) == PARTIAL_WAKE_LATENCY) begin
               st_d = ST_IDLE;
               cnt_d = '0;
            end
         end
         ST_WAKE: begin
            if (done_s != dseen_q) begin
               st_d = ST_IDLE;
            end
         end
      endcase
      unique case (st_d)
         ST_PDP: mode_d = MODE_PART;
         ST_PDF: mode_d = MODE_FULL;
         ST_WAKE: mode_d = MODE_WAKE;
         default: mode_d = MODE_NORMAL;
      endcase
   end

   always_ff @(posedge i_sclk) begin
      if (!srst_n) begin
         st_q <= ST_IDLE;
         cnt_q <= '0;
         trial_q <= '0;
         trig_q <= 1'b0;
         oe_q <= 1'b0;
         dout_q <= 1'b0;
         hold_q <= 1'b0;
         cal_q <= 1'b0;
         wtgl_q <= 1'b0;
         dseen_q <= 1'b0;
         mode_q <= MODE_NORMAL;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         trial_q <= trial_d;
         trig_q <= i_conversion_trigger;
         oe_q <= oe_d;
         dout_q <= dout_d;
         hold_q <= hold_d;
         cal_q <= cal_d;
         wtgl_q <= wtgl_d;
         dseen_q <= done_s;
         mode_q <= mode_d;
      end
   end

   // Fall acts at once, before the next clock edge
   assign o_dout_oe = (oe_q && !(st_q == ST_TAIL && i_conversion_trigger))
                      || start;
   assign o_track = !(hold_q || start);
   assign o_dout = dout_q;
   assign o_dac_code = trial_q;

   // ****************************************
   // System clock domain: power-up timer
   // ****************************************
   logic [3:0] c_sync;
   logic wseen_q, wseen_d, busy_q, busy_d, done_tgl_d;
   logic [PW-1:0] pcnt_q, pcnt_d;

   sadc_sync #(.WIDTH(4)) u_sync_c (
      .i_clk(i_clk),
      .i_d({wtgl_q, cal_q, mode_q}),
      .o_q(c_sync)
   );

   always_comb begin
      wseen_d = c_sync[3];
      busy_d = busy_q;
      pcnt_d = pcnt_q;
      done_tgl_d = done_tgl_q;
      if (c_sync[3] != wseen_q) begin
         busy_d = 1'b1;
         pcnt_d = '0;
      end else if (busy_q) begin
         pcnt_d = pcnt_q + 1'b1;
         if (pcnt_q == PW'(PWRUP_CYCLES - 1)) begin
            busy_d = 1'b0;
            done_tgl_d = !done_tgl_q;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         wseen_q <= 1'b0;
         busy_q <= 1'b0;
         pcnt_q <= '0;
         done_tgl_q <= 1'b0;
      end else begin
         wseen_q <= wseen_d;
         busy_q <= busy_d;
         pcnt_q <= pcnt_d;
         done_tgl_q <= done_tgl_d;
      end
   end

   assign o_pwr_mode = c_sync[1:0];
   assign o_calibrated = c_sync[2];
   assign o_power_ready = !busy_q;

   // ****************************************
   // Checks
   // ****************************************
   sequence s_start;
      start && !i_conversion_trigger;
   endsequence
   // Trigger low on edges 2 to 14, so no abort is allowed
   sequence s_low_run;
      (!i_conversion_trigger)[*8] ##1 (!i_conversion_trigger)[*5];
   endsequence
   sequence s_conv_tail;
      (st_q == ST_CONV)[*2] ##1 (st_q != ST_CONV);
   endsequence
   sequence s_recover_entry;
      (st_q == ST_RECOVER) && ($past(st_q) != ST_RECOVER);
   endsequence
   sequence s_recover_run;
      (st_q == ST_RECOVER)[*8] ##1 (st_q == ST_RECOVER)[*8];
   endsequence

   chk_fall_starts: assert property (
      @(posedge i_sclk) disable iff (!srst_n)
      s_start |=> (cnt_q == 5'h01 && hold_q && oe_q && !dout_q))
      else $error("trigger fall did not start a conversion");
   chk_conv_length: assert property (
      @(posedge i_sclk) disable iff (!srst_n)
      s_start ##1 s_low_run |=> s_conv_tail)
      else $error("conversion did not last sixteen edges");
   chk_conv_end: assert property (
      @(posedge i_sclk) disable iff (!srst_n)
      (st_q == ST_CONV && int'(cnt_q) == 15 && !i_conversion_trigger)
      |=> (st_q == ST_TAIL && cal_q))
      else $error("conversion not over at sixteenth edge");
   chk_track_edge: assert property (
      @(posedge i_sclk) disable iff (!srst_n)
      (st_q == ST_CONV && int'(cnt_q) == 13) |=> (!hold_q && o_track))
      else $error("tracking not resumed at fourteenth edge");
   chk_idle_tracks: assert property (
      @(posedge i_sclk) disable iff (!srst_n)
      (st_q != ST_CONV) |-> !hold_q)
      else $error("holding outside a conversion");
   chk_lead_zeros: assert property (
      @(posedge i_sclk) disable iff (!srst_n)
      (st_q == ST_CONV && int'(cnt_q) <= LEAD_ZEROS)
      |-> (o_dout_oe && !o_dout))
      else $error("leading bits not driven zero");
   chk_msb_out: assert property (
      @(posedge i_sclk) disable iff (!srst_n)
      (st_q == ST_CONV && int'(cnt_q) == 3 && !i_conversion_trigger)
      |=> (o_dout == ($past(i_cmp_above) ^ BIPOLAR)))
      else $error("MSB not shown after fourth edge");
   chk_pd_entry: assert property (
      @(posedge i_sclk) disable iff (!srst_n)
      (st_q == ST_CONV && sadc_in_range(cnt_q, 3, 13) &&
       i_conversion_trigger) |=> (st_q == ST_PDP && !o_dout_oe))
      else $error("early rise did not enter partial power-down");
   chk_continuous: assert property (
      @(posedge i_sclk) disable iff (!srst_n)
      (st_q == ST_CONV && int'(cnt_q) == 15 && i_conversion_trigger)
      |=> (st_q == ST_IDLE && o_dout_oe))
      else $error("output released in continuous mode");
   chk_tail_release: assert property (
      @(posedge i_sclk) disable iff (!srst_n)
      (st_q == ST_TAIL) |=> !oe_q)
      else $error("output not released after frame");
   chk_recover_len: assert property (
      @(posedge i_sclk) disable iff (!srst_n)
      s_recover_entry |-> s_recover_run ##1 (st_q == ST_IDLE))
      else $error("restart interval not sixteen edges");
   chk_recover_hold: assert property (
      @(posedge i_sclk) disable iff (!srst_n)
      (st_q == ST_RECOVER && int'(cnt_q) < 15) |=> (st_q == ST_RECOVER))
      else $error("restart interval cut short");
   chk_pwrup_wait: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      $rose(busy_q) |-> busy_q[*8])
      else $error("power-up wait ended early");
endmodule

// *** tb/sadc_host_model.sv ***
// Host model: serial clock master, drives the trigger, reads the data pin.
// Assumes the converter answers on rising serial clock edges.
`timescale 1ns/1ns

module sadc_host_model (
   output logic o_sclk,
   output logic o_trig,
   input wire logic i_dout,
   input wire logic i_dout_oe,
   input wire logic i_track
);
   logic last;

   // ****************************************
   // Idle levels
   // ****************************************
   initial begin
      o_sclk = 1'b0;
      o_trig = 1'b1;
      last = 1'b0;
   end

   // ****************************************
   // Clock bursts, clock stands still after
   // ****************************************
   task automatic clocks(input int n, input logic trig);
      o_trig = trig;
      repeat (n) begin
         #3 o_sclk = 1'b1;
         #3 o_sclk = 1'b0;
      end
   endtask

   // ****************************************
   // One frame, trigger raised after edge rise_at
   // ****************************************
   task automatic frame(input int n, input int rise_at, output logic pre_oe,
      output logic [15:0] data, output logic [15:0] oe,
      output logic [15:0] trk);
      logic pin;
      data = '0;
      oe = '0;
      trk = '0;
      o_trig = 1'b0;
      #1 pre_oe = i_dout_oe;
      #2;
      for (int k = 1; k <= n; k++) begin
         o_sclk = 1'b1;
         // Released pin shows a toggling level, never a held value
         #2 pin = i_dout_oe ? i_dout : ~last;
         last = pin;
         data = {data[14:0], pin};
         oe = {oe[14:0], i_dout_oe};
         trk = {trk[14:0], i_track};
         #1 o_sclk = 1'b0;
         if (k == rise_at) o_trig = 1'b1;
         #3;
      end
   endtask
endmodule

// *** tb/tb_top.sv ***
// Testbench: unipolar and bipolar converters sharing one host model.
// Assumes the comparator settles well within one serial clock period.
`timescale 1ns/1ns

module tb_top;
   import sadc_pkg::*;
   localparam int PWR = 20;
   typedef struct packed {
      logic [11:0] code;
      logic [15:0] word;
      logic [15:0] bip;
   } sadc_row_t;
   sadc_row_t rows [6] = '{'{12'h000, 16'h0000, 16'h1000},
      '{12'hFFF, 16'h1FFE, 16'h0FFE}, '{12'h800, 16'h1000, 16'h0000},
      '{12'h7FF, 16'h0FFE, 16'h1FFE}, '{12'hA5A, 16'h14B4, 16'h04B4},
      '{12'h001, 16'h0002, 16'h1002}};
   logic clk, nrst, sclk, trig, cmp_u, cmp_b, dout_u, oe_u, trk_u;
   logic dout_b, cal_u, rdy_u, pre, saw_low, saw_wake;
   logic [11:0] dac_u, dac_b, target;
   logic [1:0] mode_u;
   logic [15:0] data, oe, trk, bip_sr;
   int err_total = 0;
   int check_count = 0;

   // ****************************************
   // Clock, analog side, instances
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   assign cmp_u = (target >= dac_u);
   assign cmp_b = (target >= dac_b);
   always @(posedge sclk) begin
      #2 bip_sr = {bip_sr[14:0], dout_b};
   end

   sadc_host_model host (.o_sclk(sclk), .o_trig(trig), .i_dout(dout_u),
      .i_dout_oe(oe_u), .i_track(trk_u));
   sadc_top #(.BIPOLAR(1'b0), .PWRUP_CYCLES(PWR)) i_dut (.i_clk(clk),
      .i_nrst(nrst), .i_sclk(sclk), .i_conversion_trigger(trig),
      .i_cmp_above(cmp_u), .o_dout(dout_u), .o_dout_oe(oe_u),
      .o_track(trk_u), .o_dac_code(dac_u), .o_pwr_mode(mode_u),
      .o_calibrated(cal_u), .o_power_ready(rdy_u));
   sadc_top #(.BIPOLAR(1'b1), .PWRUP_CYCLES(PWR)) i_dut_bip (.i_clk(clk),
      .i_nrst(nrst), .i_sclk(sclk), .i_conversion_trigger(trig),
      .i_cmp_above(cmp_b), .o_dout(dout_b), .o_dout_oe(),
      .o_track(), .o_dac_code(dac_b), .o_pwr_mode(),
      .o_calibrated(), .o_power_ready());

   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input string name, input logic [15:0] exp,
      input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", name, exp, got);
         err_total++;
      end
   endtask

   task automatic waitc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #300000;
      err_total++;
      tally_and_finish;
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      nrst = 1'b0;
      target = 12'h000;
      bip_sr = '0;
      // Serial clock must run through reset
      fork
         host.clocks(80, 1'b1);
         begin
            waitc(10);
            chk("oe reset", 16'h0000, {15'h0, oe_u});
            chk("track reset", 16'h0001, {15'h0, trk_u});
            chk("dac reset", 16'h0000, {4'h0, dac_u});
            nrst = 1'b1;
         end
      join
      chk("mode reset", 16'h0000, {14'h0, mode_u});
      chk("cal reset", 16'h0000, {15'h0, cal_u});
      chk("ready reset", 16'h0001, {15'h0, rdy_u});
      // Back-to-back frames, three acquisition cycles only
      foreach (rows[i]) begin
         target = rows[i].code;
         host.frame(16, 14, pre, data, oe, trk);
         chk("pre oe", 16'h0001, {15'h0, pre});
         chk("data", rows[i].word, data);
         chk("bipolar data", rows[i].bip, bip_sr);
         chk("drive", 16'hFFFF, oe);
         chk("track", 16'h0007, trk);
      end
      waitc(5);
      chk("calibrated", 16'h0001, {15'h0, cal_u});
      // Trigger held low past edge 16
      host.frame(17, 0, pre, data, oe, trk);
      chk("release", 16'hFFFE, oe);
      host.clocks(2, 1'b1);
      // Abort at edge 5: partial power-down, then exit
      host.frame(6, 4, pre, data, oe, trk);
      chk("abort drive", 16'h003C, oe);
      waitc(8);
      chk("mode part", {14'h0, MODE_PART}, {14'h0, mode_u});
      host.clocks(16, 1'b0);
      host.clocks(18, 1'b1);
      waitc(8);
      chk("mode normal", {14'h0, MODE_NORMAL}, {14'h0, mode_u});
      target = 12'h123;
      host.frame(16, 14, pre, data, oe, trk);
      chk("data after part", 16'h0246, data);
      // Full power-down needs partial first
      host.frame(6, 4, pre, data, oe, trk);
      waitc(8);
      chk("mode part 2", {14'h0, MODE_PART}, {14'h0, mode_u});
      host.frame(6, 4, pre, data, oe, trk);
      waitc(8);
      chk("mode full", {14'h0, MODE_FULL}, {14'h0, mode_u});
      host.clocks(16, 1'b0);
      saw_low = 1'b0;
      saw_wake = 1'b0;
      fork
         host.clocks(300, 1'b1);
         repeat (45) begin
            @(negedge clk);
            if (rdy_u === 1'b0) saw_low = 1'b1;
            if (mode_u === MODE_WAKE) saw_wake = 1'b1;
         end
      join
      chk("ready low", 16'h0001, {15'h0, saw_low});
      chk("mode wake", 16'h0001, {15'h0, saw_wake});
      waitc(4);
      chk("ready high", 16'h0001, {15'h0, rdy_u});
      chk("mode after full", {14'h0, MODE_NORMAL}, {14'h0, mode_u});
      target = 12'h5A5;
      host.frame(16, 14, pre, data, oe, trk);
      chk("data after full", 16'h0B4A, data);
      tally_and_finish;
   end
endmodule
